// *** include/slbe_defines.vh ***
// constants for the shift, logic and branch execution block
// assumes a 24-bit core word and a single core clock
// Overview of operation
// (RULE1) immediate AND into selected control register
// (RULE2) flags change only for condition code target
// (RULE3) clear each flag where immediate bit zero
// (RULE4) single left shift: msb to carry, zero in
// (RULE5) multi left shift: last out bit to carry
// (RULE6) count from 6-bit immediate or register bits
// (RULE7) zero shift count clears carry
// (RULE8) overflow if bit 55 changes during shift
// (RULE9) left shift covers all 56 bits
// (RULE10) single right shift: lsb to carry, msb kept
// (RULE11) multi right shift: sign fill, last out carry
// (RULE12) right shift 56 bits, 40 in sixteen-bit mode
// (RULE13) software keeps right count within operand width
// (RULE14) right shift always clears overflow
// (RULE15) other flags follow usual definitions
// (RULE16) branch taken adds displacement, else pc plus one
// (RULE17) long displacement is signed 24-bit
// (RULE18) short 9-bit displacement sign-extended
// (RULE19) register displacement from one of eight
// (RULE20) n top bit, z all zero, l sticky
`ifndef SLBE_DEFINES_VH
`define SLBE_DEFINES_VH
// register bus word indices
`define SLBE_ADR_STATUS 5'h00
`define SLBE_ADR_OPMODE 5'h01
`define SLBE_ADR_PC 5'h02
`define SLBE_ADR_A0 5'h03
`define SLBE_ADR_A1 5'h04
`define SLBE_ADR_A2 5'h05
`define SLBE_ADR_B0 5'h06
`define SLBE_ADR_B1 5'h07
`define SLBE_ADR_B2 5'h08
`define SLBE_ADR_X0 5'h09
`define SLBE_ADR_R0 5'h10
// status word fields
`define SLBE_SA_BIT 17
`define SLBE_ST_WRMASK 24'h02FFFF
// flag positions in the condition code byte
`define SLBE_F_C 0
`define SLBE_F_V 1
`define SLBE_F_Z 2
`define SLBE_F_N 3
`define SLBE_F_U 4
`define SLBE_F_E 5
`define SLBE_F_L 6
// operations
`define SLBE_OP_AND_IMMEDIATE_CTRL 3'h1
`define SLBE_OP_ASL 3'h2
`define SLBE_OP_ASR 3'h3
`define SLBE_OP_BRA 3'h4
// immediate AND targets
`define SLBE_T_MODE 2'h0
`define SLBE_T_CCR 2'h1
`define SLBE_T_OPMODE 2'h2
// branch forms
`define SLBE_B_LONG 2'h0
`define SLBE_B_SHORT 2'h1
`define SLBE_B_REG 2'h2
// shift widths
`define SLBE_MSB 55
`define SLBE_SA_LSB 16
`endif

// *** rtl/slbe_exec.v ***
// shift, logic and branch execution unit with its accumulators and control registers
// assumes decoded instructions from same-clock decode logic, one per valid cycle
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "slbe_defines.vh"
module slbe_exec (
   input wire clk_sys_in,
   input wire rst_in,
   input wire [4:0] reg_addr_in,
   input wire [23:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output reg [23:0] reg_rdata_out,
   input wire exec_valid_in,
   input wire [2:0] exec_op_in,
   input wire [7:0] exec_imm_in,
   input wire [1:0] exec_target_in,
   input wire exec_multi_in,
   input wire exec_cnt_from_reg_in,
   input wire [2:0] exec_cnt_reg_in,
   input wire exec_src_acc_in,
   input wire exec_dst_acc_in,
   input wire [1:0] exec_bra_form_in,
   input wire exec_cond_true_in,
   input wire [23:0] exec_long_disp_in,
   input wire [8:0] exec_short_disp_in,
   input wire [2:0] address_reg_sel_in,
   output reg exec_done_out,
   output reg [23:0] pc_out,
   output reg [23:0] status_reg_out
);

////////////////////////////////////////////////////////////////////////////////
// architectural state

reg [23:0] status_reg;
reg [23:0] operating_mode_reg;
reg [23:0] pc;
reg [55:0] acc_a;
reg [55:0] acc_b;
reg [23:0] xy_reg [0:3];
reg [23:0] addr_reg [0:7];
integer k;

wire [7:0] cond_code_reg = status_reg[7:0];
wire [7:0] mode_reg = status_reg[15:8];
wire sixteen_bit_arith_flag = status_reg[`SLBE_SA_BIT];

////////////////////////////////////////////////////////////////////////////////
// shift operand and count

reg [55:0] shift_src;
reg [23:0] cnt_word;
reg [5:0] shift_cnt;

always @*
begin
   shift_src = exec_src_acc_in ? acc_b : acc_a;
   if (!exec_multi_in)
   begin
      shift_src = exec_dst_acc_in ? acc_b : acc_a;
   end
   case (exec_cnt_reg_in)
      3'h0: cnt_word = xy_reg[0];
      3'h1: cnt_word = xy_reg[1];
      3'h2: cnt_word = xy_reg[2];
      3'h3: cnt_word = xy_reg[3];
      3'h4: cnt_word = acc_a[47:24];
      3'h5: cnt_word = acc_b[47:24];
      default: cnt_word = 24'h000000;
   endcase
   if (!exec_multi_in)
   begin
      shift_cnt = 6'h01;
   end
   else if (exec_cnt_from_reg_in)
   begin
      shift_cnt = cnt_word[5:0]; // [RULE6]
   end
   else
   begin
      shift_cnt = exec_imm_in[5:0]; // [RULE6]
   end
end

////////////////////////////////////////////////////////////////////////////////
// left shift overflow: any bit among the top count+1 differing from bit 55

wire [55:0] ovf_bit;
genvar gi;
generate
   for (gi = 0; gi < 56; gi = gi + 1)
   begin : g_ovf
      localparam [6:0] POS = gi;
      assign ovf_bit[gi] = (({1'b0, shift_cnt} + POS) >= 7'd55) &
         (shift_src[gi] ^ shift_src[`SLBE_MSB]); // [RULE8]
   end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// shifters

wire [119:0] asl_wide = {63'h0, 1'b0, shift_src} << shift_cnt; // [RULE9]
wire [55:0] asl_res = asl_wide[55:0]; // [RULE4] [RULE5]
wire asl_carry = (shift_cnt != 6'h00) & asl_wide[56]; // [RULE5] [RULE7]
wire asl_ovf = (shift_cnt != 6'h00) & (|ovf_bit); // [RULE8]

wire signed [56:0] asr_ext56 = {shift_src, 1'b0};
wire signed [56:0] asr_sh56 = asr_ext56 >>> shift_cnt; // [RULE11]
wire signed [40:0] asr_ext40 = {shift_src[55:16], 1'b0};
wire signed [40:0] asr_sh40 = asr_ext40 >>> shift_cnt; // [RULE12]

reg [55:0] asr_res;
reg asr_carry;

always @*
begin
   if (sixteen_bit_arith_flag)
   begin
      asr_res = {asr_sh40[40:1], 16'h0000}; // [RULE12]
      asr_carry = asr_sh40[0];
   end
   else
   begin
      asr_res = asr_sh56[56:1]; // [RULE10] [RULE11]
      asr_carry = asr_sh56[0];
   end
   if (shift_cnt == 6'h00)
   begin
      asr_carry = 1'b0; // [RULE7]
   end
end

////////////////////////////////////////////////////////////////////////////////
// flag update for shifts

reg [55:0] sh_res;
reg sh_carry;
reg sh_ovf;
reg [7:0] sh_ccr;

always @*
begin
   if (exec_op_in == `SLBE_OP_ASL)
   begin
      sh_res = asl_res;
      sh_carry = asl_carry;
      sh_ovf = asl_ovf;
   end
   else
   begin
      sh_res = asr_res;
      sh_carry = asr_carry;
      sh_ovf = 1'b0; // [RULE14]
   end
   sh_ccr = cond_code_reg;
   sh_ccr[`SLBE_F_C] = sh_carry;
   sh_ccr[`SLBE_F_V] = sh_ovf;
   sh_ccr[`SLBE_F_Z] = (sh_res == 56'h0); // [RULE15] [RULE20]
   sh_ccr[`SLBE_F_N] = sh_res[`SLBE_MSB]; // [RULE20]
   sh_ccr[`SLBE_F_U] = ~(sh_res[47] ^ sh_res[46]); // [RULE15]
   sh_ccr[`SLBE_F_E] = ~((&sh_res[55:47]) | ~(|sh_res[55:47])); // [RULE15]
   sh_ccr[`SLBE_F_L] = cond_code_reg[`SLBE_F_L] | sh_ovf; // [RULE20]
end

////////////////////////////////////////////////////////////////////////////////
// branch target

reg [23:0] bra_disp;
reg [23:0] next_pc;

always @*
begin
   case (exec_bra_form_in)
      `SLBE_B_LONG: bra_disp = exec_long_disp_in; // [RULE17]
      `SLBE_B_SHORT: bra_disp = {{15{exec_short_disp_in[8]}}, exec_short_disp_in}; // [RULE18]
      `SLBE_B_REG: bra_disp = addr_reg[address_reg_sel_in]; // [RULE19]
      default: bra_disp = 24'h000000;
   endcase
   if (exec_cond_true_in)
   begin
      next_pc = pc + bra_disp; // [RULE16] [RULE17]
   end
   else
   begin
      next_pc = pc + 24'h000001; // [RULE16]
   end
end

////////////////////////////////////////////////////////////////////////////////
// state update: execution wins over a bus write in the same cycle

always @(posedge clk_sys_in or posedge rst_in)
begin
   if (rst_in)
   begin
      status_reg <= 24'h000000;
      operating_mode_reg <= 24'h000000;
      pc <= 24'h000000;
      acc_a <= 56'h0;
      acc_b <= 56'h0;
      for (k = 0; k < 4; k = k + 1)
      begin
         xy_reg[k] <= 24'h000000;
      end
      for (k = 0; k < 8; k = k + 1)
      begin
         addr_reg[k] <= 24'h000000;
      end
   end
   else
   begin
      if (reg_wr_in)
      begin
         case (reg_addr_in)
            `SLBE_ADR_STATUS: status_reg <= reg_wdata_in & `SLBE_ST_WRMASK;
            `SLBE_ADR_OPMODE: operating_mode_reg <= reg_wdata_in;
            `SLBE_ADR_PC: pc <= reg_wdata_in;
            `SLBE_ADR_A0: acc_a[23:0] <= reg_wdata_in;
            `SLBE_ADR_A1: acc_a[47:24] <= reg_wdata_in;
            `SLBE_ADR_A2: acc_a[55:48] <= reg_wdata_in[7:0];
            `SLBE_ADR_B0: acc_b[23:0] <= reg_wdata_in;
            `SLBE_ADR_B1: acc_b[47:24] <= reg_wdata_in;
            `SLBE_ADR_B2: acc_b[55:48] <= reg_wdata_in[7:0];
            5'h09: xy_reg[0] <= reg_wdata_in;
            5'h0A: xy_reg[1] <= reg_wdata_in;
            5'h0B: xy_reg[2] <= reg_wdata_in;
            5'h0C: xy_reg[3] <= reg_wdata_in;
            default:
            begin
               if (reg_addr_in[4:3] == 2'h2)
               begin
                  addr_reg[reg_addr_in[2:0]] <= reg_wdata_in;
               end
            end
         endcase
      end
      if (exec_valid_in)
      begin
         case (exec_op_in)
            `SLBE_OP_AND_IMMEDIATE_CTRL:
            begin
               case (exec_target_in)
                  `SLBE_T_MODE: status_reg[15:8] <= mode_reg & exec_imm_in; // [RULE1] [RULE2]
                  `SLBE_T_CCR: status_reg[7:0] <= cond_code_reg & exec_imm_in; // [RULE1] [RULE3]
                  `SLBE_T_OPMODE:
                  begin
                     operating_mode_reg[7:0] <= operating_mode_reg[7:0] & exec_imm_in; // [RULE1]
                  end
                  default:
                  begin
                     status_reg <= status_reg;
                  end
               endcase
            end
            `SLBE_OP_ASL, `SLBE_OP_ASR:
            begin
               status_reg[7:0] <= sh_ccr; // [RULE15]
               if (exec_dst_acc_in)
               begin
                  acc_b <= sh_res;
               end
               else
               begin
                  acc_a <= sh_res;
               end
            end
            `SLBE_OP_BRA:
            begin
               pc <= next_pc; // [RULE16]
            end
            default:
            begin
               pc <= pc;
            end
         endcase
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// read port and outputs

reg [23:0] next_rdata;

always @*
begin
   next_rdata = 24'h000000;
   case (reg_addr_in)
      `SLBE_ADR_STATUS: next_rdata = status_reg;
      `SLBE_ADR_OPMODE: next_rdata = operating_mode_reg;
      `SLBE_ADR_PC: next_rdata = pc;
      `SLBE_ADR_A0: next_rdata = acc_a[23:0];
      `SLBE_ADR_A1: next_rdata = acc_a[47:24];
      `SLBE_ADR_A2: next_rdata = {16'h0000, acc_a[55:48]};
      `SLBE_ADR_B0: next_rdata = acc_b[23:0];
      `SLBE_ADR_B1: next_rdata = acc_b[47:24];
      `SLBE_ADR_B2: next_rdata = {16'h0000, acc_b[55:48]};
      5'h09: next_rdata = xy_reg[0];
      5'h0A: next_rdata = xy_reg[1];
      5'h0B: next_rdata = xy_reg[2];
      5'h0C: next_rdata = xy_reg[3];
      default:
      begin
         if (reg_addr_in[4:3] == 2'h2)
         begin
            next_rdata = addr_reg[reg_addr_in[2:0]];
         end
      end
   endcase
end

always @(posedge clk_sys_in or posedge rst_in)
begin
   if (rst_in)
   begin
      reg_rdata_out <= 24'h000000;
      exec_done_out <= 1'b0;
      pc_out <= 24'h000000;
      status_reg_out <= 24'h000000;
   end
   else
   begin
      reg_rdata_out <= reg_rd_in ? next_rdata : 24'h000000;
      exec_done_out <= exec_valid_in;
      pc_out <= pc;
      status_reg_out <= status_reg;
   end
end

endmodule

// *** tb/slbe_dec_model.sv ***
// decode side model driving the instruction port of the execution unit
// assumes the bench calls issue, one instruction at a time
`timescale 1ns/1ps
module slbe_dec_model (
   input wire clk_sys_in,
   output reg valid_out,
   output reg [2:0] op_out,
   output reg [7:0] imm_out,
   output reg [1:0] target_out,
   output reg multi_out,
   output reg cfr_out,
   output reg [2:0] creg_out,
   output reg src_out,
   output reg dst_out,
   output reg [1:0] form_out,
   output reg cond_out,
   output reg [23:0] ldisp_out,
   output reg [8:0] sdisp_out,
   output reg [2:0] rsel_out
);
initial
begin
   {valid_out, op_out, imm_out, target_out, multi_out, cfr_out, creg_out} = 19'h00000;
   {src_out, dst_out, form_out, cond_out, ldisp_out, sdisp_out, rsel_out} = 41'h0;
end
////////////////////////////////////////////////////////////////////////////////
task issue(input [2:0] o, input [7:0] i, input [9:0] s, input [23:0] d);
begin
   @(posedge clk_sys_in);
   valid_out <= 1'h1;
   op_out <= o;
   imm_out <= i; // count kept within operand width
   {cond_out, dst_out, src_out, cfr_out, multi_out} <= s[6:2];
   {target_out, form_out} <= {s[1:0], s[1:0]};
   {creg_out, rsel_out} <= {s[9:7], s[9:7]};
   ldisp_out <= d;
   sdisp_out <= d[8:0];
   @(posedge clk_sys_in);
   valid_out <= 1'h0;
   imm_out <= ~i;
   ldisp_out <= ~d;
   sdisp_out <= ~d[8:0];
end
endtask
endmodule

// *** tb/slbe_exec_asserts.sv ***
// concurrent checks on the execution unit ports
// assumes the bind below and one core clock
`timescale 1ns/1ps
module slbe_exec_asserts (
   input wire clk_sys_in,
   input wire rst_in,
   input wire reg_wr_in,
   input wire exec_valid_in,
   input wire [2:0] exec_op_in,
   input wire [7:0] exec_imm_in,
   input wire [1:0] exec_target_in,
   input wire exec_multi_in,
   input wire exec_cnt_from_reg_in,
   input wire exec_cond_true_in,
   input wire [1:0] exec_bra_form_in,
   input wire [23:0] exec_long_disp_in,
   input wire [8:0] exec_short_disp_in,
   input wire [23:0] pc_out,
   input wire exec_done_out,
   input wire [23:0] status_reg_out
);
default clocking cb @(posedge clk_sys_in);
endclocking
default disable iff (rst_in);
wire go = exec_valid_in;
wire bra = go && exec_op_in == 3'h4 && exec_cond_true_in;
wire [23:0] sx = {{15{exec_short_disp_in[8]}}, exec_short_disp_in};
////////////////////////////////////////////////////////////////////////////////
a_and_immediate_ctrl_mode: assert property (
   go && exec_op_in == 3'h1 && exec_target_in == 2'h0
   |-> ##2 (status_reg_out[15:8] & ~$past(exec_imm_in, 2)) == 8'h00) else $error("mode bit kept");
a_and_immediate_ctrl_ccr: assert property (
   go && exec_op_in == 3'h1 && exec_target_in == 2'h1
   |-> ##2 (status_reg_out[7:0] & ~$past(exec_imm_in, 2)) == 8'h00) else $error("flag kept");
a_asr_ovf: assert property (
   go && exec_op_in == 3'h3 |-> ##2 !status_reg_out[1]) else $error("right shift overflow");
a_done_pulse: assert property (
   exec_done_out == $past(exec_valid_in)) else $error("done not one cycle after valid");
a_zero_cnt: assert property (
   go && exec_op_in[2:1] == 2'h1 && exec_multi_in && !exec_cnt_from_reg_in
   && exec_imm_in[5:0] == 6'h00 |-> ##2 !status_reg_out[0]) else $error("carry on zero count");
a_ovf_sticky: assert property (
   go && exec_op_in == 3'h2 |-> ##2 (!status_reg_out[1] || status_reg_out[6]))
   else $error("limit not set");
a_bra_seq: assert property (
   go && exec_op_in == 3'h4 && !exec_cond_true_in && !$past(go) && !$past(reg_wr_in)
   |-> ##2 pc_out == $past(pc_out) + 24'h000001) else $error("pc not advanced");
a_bra_long: assert property (
   bra && exec_bra_form_in == 2'h0 && !$past(go) && !$past(reg_wr_in)
   |-> ##2 pc_out == $past(pc_out) + $past(exec_long_disp_in, 2)) else $error("long branch");
a_bra_short: assert property (
   bra && exec_bra_form_in == 2'h1 && !$past(go) && !$past(reg_wr_in)
   |-> ##2 pc_out == $past(pc_out) + $past(sx, 2)) else $error("short branch");
endmodule
bind slbe_exec slbe_exec_asserts chk (
   .clk_sys_in(clk_sys_in),
   .rst_in(rst_in),
   .reg_wr_in(reg_wr_in),
   .exec_valid_in(exec_valid_in),
   .exec_op_in(exec_op_in),
   .exec_imm_in(exec_imm_in),
   .exec_target_in(exec_target_in),
   .exec_multi_in(exec_multi_in),
   .exec_cnt_from_reg_in(exec_cnt_from_reg_in),
   .exec_cond_true_in(exec_cond_true_in),
   .exec_bra_form_in(exec_bra_form_in),
   .exec_long_disp_in(exec_long_disp_in),
   .exec_short_disp_in(exec_short_disp_in),
   .pc_out(pc_out),
   .exec_done_out(exec_done_out),
   .status_reg_out(status_reg_out)
);

// *** tb/test_slbe_exec.sv ***
// self-checking bench for the execution unit
// assumes the decode model drives the instruction port
`timescale 1ns/1ps
module test_slbe_exec;
reg clk_sys_in = 1'h0;
reg rst_in = 1'h1;
reg [4:0] ra = 5'h00;
reg [23:0] wd = 24'h000000;
reg we = 1'h0;
reg re = 1'h0;
wire [23:0] rdat, pc, st, ld;
wire v, mu, cf, sr, ds, cd, done;
wire [2:0] op, cr, rs;
wire [7:0] im;
wire [1:0] tg, fm;
wire [8:0] sd;
integer error_cnt = 0;
integer n_checks = 0;
always #4 clk_sys_in = ~clk_sys_in;
slbe_dec_model m (.clk_sys_in(clk_sys_in), .valid_out(v), .op_out(op), .imm_out(im),
   .target_out(tg), .multi_out(mu), .cfr_out(cf), .creg_out(cr), .src_out(sr),
   .dst_out(ds), .form_out(fm), .cond_out(cd), .ldisp_out(ld), .sdisp_out(sd),
   .rsel_out(rs));
slbe_exec dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(ra),
   .reg_wdata_in(wd), .reg_wr_in(we), .reg_rd_in(re), .reg_rdata_out(rdat),
   .exec_valid_in(v), .exec_op_in(op), .exec_imm_in(im), .exec_target_in(tg),
   .exec_multi_in(mu), .exec_cnt_from_reg_in(cf), .exec_cnt_reg_in(cr),
   .exec_src_acc_in(sr), .exec_dst_acc_in(ds), .exec_bra_form_in(fm),
   .exec_cond_true_in(cd), .exec_long_disp_in(ld), .exec_short_disp_in(sd),
   .address_reg_sel_in(rs), .exec_done_out(done), .pc_out(pc), .status_reg_out(st));
////////////////////////////////////////////////////////////////////////////////
task chk(input [23:0] seen, input [23:0] exp);
begin
   n_checks = n_checks + 1;
   if (seen !== exp)
   begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
   end
end
endtask
task wr(input [4:0] a, input [23:0] d);
begin
   @(posedge clk_sys_in);
   ra <= a;
   wd <= d;
   we <= 1'h1;
   @(posedge clk_sys_in);
   we <= 1'h0;
end
endtask
task rd(input [4:0] a, input [23:0] e);
begin
   @(posedge clk_sys_in);
   ra <= a;
   re <= 1'h1;
   @(posedge clk_sys_in);
   re <= 1'h0;
   #2 chk(rdat, e);
end
endtask
task stop_test;
begin
   $display("checks %0d errors %0d", n_checks, error_cnt);
   if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
   else
      $display("SIMULATION FAILED");
   $finish;
end
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
   #20000;
   error_cnt = error_cnt + 1;
   stop_test;
end
initial
begin
   repeat (16) @(posedge clk_sys_in);
   rst_in <= 1'h0;
   rd(5'h0D, 24'h000000);
   wr(5'h05, 24'h000040);
   wr(5'h04, 24'h000000);
   wr(5'h03, 24'h000004);
   m.issue(3'h2, 8'h00, 10'h000, 24'h000000);
   rd(5'h05, 24'h000080);
   rd(5'h03, 24'h000008);
   rd(5'h00, 24'h00007A);
   wr(5'h00, 24'h00A57A);
   m.issue(3'h1, 8'h0F, 10'h000, 24'h000000);
   rd(5'h00, 24'h00057A);
   m.issue(3'h1, 8'hF5, 10'h001, 24'h000000);
   rd(5'h00, 24'h000570);
   wr(5'h01, 24'h1234FF);
   m.issue(3'h1, 8'h0F, 10'h002, 24'h000000);
   rd(5'h01, 24'h12340F);
   wr(5'h09, 24'hFFFFC4);
   m.issue(3'h3, 8'h00, 10'h02C, 24'h000000);
   rd(5'h08, 24'h0000F8);
   rd(5'h00, 24'h000579);
   m.issue(3'h2, 8'h00, 10'h014, 24'h000000);
   rd(5'h00, 24'h000578);
   m.issue(3'h2, 8'h04, 10'h014, 24'h000000);
   rd(5'h05, 24'h000080);
   rd(5'h00, 24'h000579);
   wr(5'h03, 24'h01FFFF);
   wr(5'h00, 24'h020578);
   m.issue(3'h3, 8'h00, 10'h000, 24'h000000);
   rd(5'h05, 24'h0000C0);
   rd(5'h03, 24'h000000);
   rd(5'h00, 24'h020579);
   wr(5'h02, 24'h000100);
   m.issue(3'h4, 8'h00, 10'h040, 24'hFFFFF0);
   rd(5'h02, 24'h0000F0);
   m.issue(3'h4, 8'h00, 10'h041, 24'h0001F0);
   rd(5'h02, 24'h0000E0);
   m.issue(3'h4, 8'h00, 10'h000, 24'h000040);
   rd(5'h02, 24'h0000E1);
   wr(5'h13, 24'h000020);
   m.issue(3'h4, 8'h00, 10'h1C2, 24'h000000);
   rd(5'h02, 24'h000101);
   stop_test;
end
endmodule
